// *** rtl/intc_map.vh ***
// register map, field positions, reset values and event codes of the priority coder
`ifndef INTC_MAP_VH
`define INTC_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_PRIO_A 8'h04
`define OFF_PRIO_B 8'h08
`define OFF_PRIO_C 8'h0C
`define OFF_PRIO_D 8'h10
`define OFF_PRIO_EXT 8'h14
`define OFF_EVENT_CODE 8'h18
`define OFF_IRQ_STATUS 8'h1C
`define OFF_IRQ_MASK 8'h20
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_MODE_BIT 7
`define CTRL_NMI_RISE_BIT 8
`define CTRL_NMI_LEVEL_BIT 15
`define CTRL_WMASK 16'h0180
`define PRIO_ABC_RESET 16'h0000
`define PRIO_D_RESET 16'hDA74
`define PRIO_EXT_RESET 32'h00000000
`define PRIO_C_DBG_LSB 0
`define PRIO_C_DMA_LSB 8
`define PRIO_C_GPIO_LSB 12
`define IRQ_BITS 3
`define IRQ_ACCEPT 0
`define IRQ_NMI 1
`define IRQ_LINES 2
// ----------------------------------------
// levels and event codes
// ----------------------------------------
`define NMI_LEVEL 5'h10
`define NMI_CODE 12'h1C0
`define ENC_BASE_CODE 12'h200
`define ENC_STEP_CODE 12'h020
`define ENC_TOP_LEVEL 5'h0F
`define ENC_NONE 4'hF
`define LINE_BASE_CODE 12'h240
`define LINE_STEP_CODE 12'h060
`define DBG_CODE 12'h600
`define GPIO_CODE 12'h620
`define DMA_LOW_CODE 12'h640
`define DMA_HIGH_CODE 12'h780
`define DMA_STEP_CODE 12'h020
`define DMA_ERR_CODE 12'h6C0
`endif

// *** rtl/line_filter.v ***
// two-flop synchroniser with a three-sample stability filter for pin inputs
`timescale 1ns/100ps
`default_nettype none
module line_filter #(
    parameter W = 5,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] pin_in,
    output reg [W-1:0] stable_ff
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    reg [W-1:0] s4_ff;
    wire agree;

    // s2, s3 and s4 are three successive bus-clock samples
    assign agree = (s2_ff == s3_ff) && (s3_ff == s4_ff);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= INIT;
            s2_ff <= INIT;
            s3_ff <= INIT;
            s4_ff <= INIT;
            stable_ff <= INIT;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            s4_ff <= s3_ff;
            if (agree) begin
                stable_ff <= s3_ff;
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/prio_select.v ***
// picks the highest-level request; lower index wins a tie
`timescale 1ns/100ps
`default_nettype none
module prio_select #(
    parameter N = 17,
    parameter LW = 5,
    parameter CW = 12,
    parameter IW = 5
) (
    input wire pclk,
    input wire presetn,
    input wire [N-1:0] req,
    input wire [N*LW-1:0] lvl,
    input wire [N*CW-1:0] code,
    output reg sel_valid_ff,
    output reg [LW-1:0] sel_level_ff,
    output reg [CW-1:0] sel_code_ff,
    output reg [IW-1:0] sel_idx_ff
);
    wire [N:0] hit;
    wire [(N+1)*LW-1:0] best_lvl;
    wire [(N+1)*CW-1:0] best_code;
    wire [(N+1)*IW-1:0] best_idx;

    assign hit[N] = 1'b0;
    assign best_lvl[N*LW +: LW] = {LW{1'b0}};
    assign best_code[N*CW +: CW] = {CW{1'b0}};
    assign best_idx[N*IW +: IW] = {IW{1'b0}};

    // chain runs from the lowest-ranked source up, so >= hands ties to the higher rank
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : chain
            localparam integer GI = g;
            wire take;
            // a level of zero never competes
            assign take = req[g] && (lvl[g*LW +: LW] != {LW{1'b0}}) &&
                (!hit[g+1] || (lvl[g*LW +: LW] >= best_lvl[(g+1)*LW +: LW]));
            assign hit[g] = take | hit[g+1];
            assign best_lvl[g*LW +: LW] = take ? lvl[g*LW +: LW] : best_lvl[(g+1)*LW +: LW];
            assign best_code[g*CW +: CW] = take ? code[g*CW +: CW] : best_code[(g+1)*CW +: CW];
            assign best_idx[g*IW +: IW] = take ? GI[IW-1:0] : best_idx[(g+1)*IW +: IW];
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_valid_ff <= 1'b0;
            sel_level_ff <= {LW{1'b0}};
            sel_code_ff <= {CW{1'b0}};
            sel_idx_ff <= {IW{1'b0}};
        end else begin
            sel_valid_ff <= hit[0];
            sel_level_ff <= best_lvl[0 +: LW];
            sel_code_ff <= best_code[0 +: CW];
            sel_idx_ff <= best_idx[0 +: IW];
        end
    end
endmodule
`default_nettype wire

// *** rtl/intc_prio_coder.v ***
// interrupt priority resolution and event-code generation with an apb register file
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "intc_map.vh"
// Operation
// - every source presents its own event code to the core.
// - all sources share one handler, which reads the event code register to find the source.
// - each peripheral group has a 4-bit level from 0 to 15 in the priority registers.
// - reset clears the debug, gpio and dma priority levels to 0.
// - equal levels pending together are resolved by the fixed default order.
// - default order is nmi, external lines, debug, gpio, then dma sources.
// - nmi is code 1C0 at level 16; encoded value n gives code 200+n*20 at level 15-n.
// - independent lines report 240, 2A0, 300, 360 with levels reset to 13, 10, 7, 4.
// - debug uses code 600 and gpio 620, each with its own level field.
// - dma sources share one field, ordered end 0-3, end 4-7, then address error.
// - a source at level 0 is masked.
// - an external line value counts after three equal samples; 1111 means no request.
// - the mode bit turns the four lines into four separate requests.
module intc_prio_coder (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire nmi_pin,
    input wire [3:0] ext_level_lines_n,
    input wire debug_interface_source,
    input wire gpio_source,
    input wire [7:0] dma_channel_end,
    input wire dma_address_error,
    input wire core_accept,
    output reg evt_valid,
    output reg [11:0] evt_code,
    output reg [4:0] evt_level,
    output reg irq
);
    localparam N = 17;
    localparam IDX_NMI = 5'h00;

    reg [15:0] ctrl_ff;
    reg [15:0] prio_a_ff;
    reg [15:0] prio_b_ff;
    reg [15:0] prio_c_ff;
    reg [15:0] prio_d_ff;
    reg [31:0] prio_ext_ff;
    reg [11:0] event_code_register_ff;
    reg [`IRQ_BITS-1:0] irq_status_ff;
    reg [`IRQ_BITS-1:0] irq_mask_ff;
    reg [`IRQ_BITS-1:0] nxt_irq_status;
    reg nmi_prev_ff;
    reg nmi_pend_ff;
    reg [3:0] lines_prev_ff;
    reg guard_ff;
    reg [4:0] evt_idx_ff;
    reg [31:0] nxt_rdata;
    reg nxt_evt_valid;
    reg [11:0] nxt_evt_code;
    reg [4:0] nxt_evt_level;
    reg [4:0] nxt_evt_idx;
    reg [11:0] nxt_event_code_register;
    reg nxt_nmi_pend;
    reg nxt_err;

    wire [4:0] pins_stable;
    wire [3:0] lines;
    wire nmi_lvl;
    wire mode_indep;
    wire nmi_edge;
    wire wr_en;
    wire accept;
    wire load;
    wire [N-1:0] req;
    wire [N*5-1:0] lvl;
    wire [N*12-1:0] code;
    wire sel_valid;
    wire [4:0] sel_level;
    wire [11:0] sel_code;
    wire [4:0] sel_idx;

    // ----------------------------------------
    // pin conditioning
    // ----------------------------------------
    line_filter #(.W(5), .INIT(5'h0F)) u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({nmi_pin, ext_level_lines_n}),
        .stable_ff(pins_stable)
    );

    assign lines = pins_stable[3:0];
    assign nmi_lvl = pins_stable[4];
    assign mode_indep = ctrl_ff[`CTRL_MODE_BIT];
    assign nmi_edge = ctrl_ff[`CTRL_NMI_RISE_BIT] ? (nmi_lvl & ~nmi_prev_ff) : (~nmi_lvl & nmi_prev_ff);

    // ----------------------------------------
    // candidate table, in default order
    // ----------------------------------------
    assign req[0] = nmi_pend_ff;
    assign lvl[0 +: 5] = `NMI_LEVEL;
    assign code[0 +: 12] = `NMI_CODE;
    // encoded value 1111 is idle
    assign req[1] = !mode_indep && (lines != `ENC_NONE);
    assign lvl[5 +: 5] = `ENC_TOP_LEVEL - {1'b0, lines};
    assign code[12 +: 12] = `ENC_BASE_CODE + {3'h0, lines, 5'h00};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : indep
            localparam integer CI = `LINE_BASE_CODE + g * `LINE_STEP_CODE;
            localparam [11:0] C = CI[11:0];
            assign req[2+g] = mode_indep && !lines[g];
            assign lvl[(2+g)*5 +: 5] = {1'b0, prio_d_ff[15-4*g -: 4]};
            assign code[(2+g)*12 +: 12] = C;
        end
        for (g = 0; g < 8; g = g + 1) begin : dma
            localparam integer CI = (g < 4) ? (`DMA_LOW_CODE + g * `DMA_STEP_CODE)
                : (`DMA_HIGH_CODE + (g - 4) * `DMA_STEP_CODE);
            localparam [11:0] C = CI[11:0];
            assign req[8+g] = dma_channel_end[g];
            assign lvl[(8+g)*5 +: 5] = {1'b0, prio_c_ff[`PRIO_C_DMA_LSB +: 4]};
            assign code[(8+g)*12 +: 12] = C;
        end
    endgenerate

    assign req[6] = debug_interface_source;
    assign lvl[30 +: 5] = {1'b0, prio_c_ff[`PRIO_C_DBG_LSB +: 4]};
    assign code[72 +: 12] = `DBG_CODE;
    assign req[7] = gpio_source;
    assign lvl[35 +: 5] = {1'b0, prio_c_ff[`PRIO_C_GPIO_LSB +: 4]};
    assign code[84 +: 12] = `GPIO_CODE;
    assign req[16] = dma_address_error;
    assign lvl[80 +: 5] = {1'b0, prio_c_ff[`PRIO_C_DMA_LSB +: 4]};
    assign code[192 +: 12] = `DMA_ERR_CODE;

    prio_select #(.N(N), .LW(5), .CW(12), .IW(5)) u_select (
        .pclk(pclk),
        .presetn(presetn),
        .req(req),
        .lvl(lvl),
        .code(code),
        .sel_valid_ff(sel_valid),
        .sel_level_ff(sel_level),
        .sel_code_ff(sel_code),
        .sel_idx_ff(sel_idx)
    );

    // ----------------------------------------
    // presentation to the core
    // ----------------------------------------
    assign accept = evt_valid && core_accept;
    // guard skips one cycle so a stale registered choice is not re-presented
    assign load = !evt_valid && !guard_ff && sel_valid;

    always @* begin
        nxt_evt_valid = evt_valid;
        nxt_evt_code = evt_code;
        nxt_evt_level = evt_level;
        nxt_evt_idx = evt_idx_ff;
        nxt_event_code_register = event_code_register_ff;
        nxt_nmi_pend = nmi_pend_ff;
        if (load) begin
            nxt_evt_valid = 1'b1;
            nxt_evt_code = sel_code;
            nxt_evt_level = sel_level;
            nxt_evt_idx = sel_idx;
        end else if (accept) begin
            nxt_evt_valid = 1'b0;
            nxt_event_code_register = evt_code;
        end
        // a fresh edge outranks the clear of the one just taken
        if (nmi_edge) begin
            nxt_nmi_pend = 1'b1;
        end else if (accept && evt_idx_ff == IDX_NMI) begin
            nxt_nmi_pend = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_valid <= 1'b0;
            evt_code <= 12'h000;
            evt_level <= 5'h00;
            evt_idx_ff <= 5'h00;
            guard_ff <= 1'b0;
            event_code_register_ff <= 12'h000;
            nmi_prev_ff <= 1'b0;
            nmi_pend_ff <= 1'b0;
            lines_prev_ff <= 4'hF;
        end else begin
            guard_ff <= accept;
            nmi_prev_ff <= nmi_lvl;
            lines_prev_ff <= lines;
            evt_valid <= nxt_evt_valid;
            evt_code <= nxt_evt_code;
            evt_level <= nxt_evt_level;
            evt_idx_ff <= nxt_evt_idx;
            event_code_register_ff <= nxt_event_code_register;
            nmi_pend_ff <= nxt_nmi_pend;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // one wait-free access phase; pready rises in the cycle after setup
    assign wr_en = psel && penable && pready && pwrite;

    always @* begin
        nxt_err = 1'b0;
        nxt_rdata = 32'h00000000;
        case (paddr)
            `OFF_CTRL: begin
                nxt_rdata = {16'h0000, ctrl_ff};
                nxt_rdata[`CTRL_NMI_LEVEL_BIT] = nmi_lvl;
            end
            `OFF_PRIO_A: nxt_rdata = {16'h0000, prio_a_ff};
            `OFF_PRIO_B: nxt_rdata = {16'h0000, prio_b_ff};
            `OFF_PRIO_C: nxt_rdata = {16'h0000, prio_c_ff};
            `OFF_PRIO_D: nxt_rdata = {16'h0000, prio_d_ff};
            `OFF_PRIO_EXT: nxt_rdata = prio_ext_ff;
            `OFF_EVENT_CODE: nxt_rdata = {20'h00000, event_code_register_ff};
            `OFF_IRQ_STATUS: nxt_rdata = {29'h00000000, irq_status_ff};
            `OFF_IRQ_MASK: nxt_rdata = {29'h00000000, irq_mask_ff};
            default: nxt_err = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && nxt_err;
            if (psel && !penable && !pwrite) begin
                prdata <= nxt_rdata;
            end
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    // writes take effect at once; ctrl has no bit that holds off arbitration around them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 16'h0000;
            prio_a_ff <= `PRIO_ABC_RESET;
            prio_b_ff <= `PRIO_ABC_RESET;
            prio_c_ff <= `PRIO_ABC_RESET;
            prio_d_ff <= `PRIO_D_RESET;
            prio_ext_ff <= `PRIO_EXT_RESET;
            irq_mask_ff <= {`IRQ_BITS{1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `OFF_CTRL: ctrl_ff <= pwdata[15:0] & `CTRL_WMASK;
                `OFF_PRIO_A: prio_a_ff <= pwdata[15:0];
                `OFF_PRIO_B: prio_b_ff <= pwdata[15:0];
                `OFF_PRIO_C: prio_c_ff <= pwdata[15:0];
                `OFF_PRIO_D: prio_d_ff <= pwdata[15:0];
                `OFF_PRIO_EXT: prio_ext_ff <= pwdata;
                `OFF_IRQ_MASK: irq_mask_ff <= pwdata[`IRQ_BITS-1:0];
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // ----------------------------------------
    // interrupt status, write one to clear
    // ----------------------------------------
    always @* begin
        nxt_irq_status = irq_status_ff;
        if (wr_en && paddr == `OFF_IRQ_STATUS) begin
            nxt_irq_status = irq_status_ff & ~pwdata[`IRQ_BITS-1:0];
        end
        // a new event beats a clear in the same cycle
        if (accept) begin
            nxt_irq_status[`IRQ_ACCEPT] = 1'b1;
        end
        if (nmi_edge) begin
            nxt_irq_status[`IRQ_NMI] = 1'b1;
        end
        if (lines != lines_prev_ff) begin
            nxt_irq_status[`IRQ_LINES] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= {`IRQ_BITS{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq <= |(nxt_irq_status & irq_mask_ff);
        end
    end
endmodule
`default_nettype wire

// *** sim/intc_prio_coder_sva.sv ***
// port assertions for the priority coder
`timescale 1ns/100ps
`default_nettype none
module intc_prio_coder_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_accept,
    input wire logic evt_valid,
    input wire logic [11:0] evt_code,
    input wire logic [4:0] evt_level
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_take;
        evt_valid && core_accept;
    endsequence
    sequence s_gap;
        !evt_valid [*2];
    endsequence
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_evt_held:
        assert property (evt_valid && !core_accept |=> evt_valid && $stable(evt_code) && $stable(evt_level))
        else $error("event changed before acceptance");
    chk_guard_gap:
        assert property (s_take |=> s_gap)
        else $error("event reloaded inside guard gap");
    chk_level_range:
        assert property (evt_valid |-> evt_level inside {[5'h01:5'h10]})
        else $error("event level out of range");
    chk_nmi_level:
        assert property (evt_valid && evt_code == 12'h1C0 |-> evt_level == 5'h10)
        else $error("nmi code with wrong level");
    chk_code_known:
        assert property (evt_valid |-> evt_code[4:0] == 5'h00 && evt_code inside {12'h1C0,
            [12'h200:12'h3C0], [12'h600:12'h6C0], [12'h780:12'h7E0]})
        else $error("unknown event code");
endmodule
bind intc_prio_coder intc_prio_coder_sva u_sva (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .core_accept, .evt_valid, .evt_code, .evt_level);
`default_nettype wire

// *** sim/core_take_model.sv ***
// core side model: takes a presented event after a chosen stall
`timescale 1ns/100ps
`default_nettype none
module core_take_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic evt_valid,
    input wire logic [3:0] stall,
    output var logic core_accept
);
    logic [3:0] wait_ff;
    // long stalls prove the coder holds its event meanwhile
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_accept <= 1'b0;
            wait_ff <= 4'h0;
        end else if (core_accept || !evt_valid) begin
            core_accept <= 1'b0;
            wait_ff <= 4'h0;
        end else if (wait_ff == stall) begin
            core_accept <= 1'b1;
        end else begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule
`default_nettype wire

// *** sim/intc_prio_coder_test.sv ***
// self-checking bench for the priority coder with a reference picker
`timescale 1ns/100ps
`default_nettype none
`include "intc_map.vh"
module intc_prio_coder_test;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic nmi_pin, debug_interface_source, gpio_source, dma_address_error, core_accept, evt_valid;
    logic [3:0] ext_level_lines_n, stall;
    logic [4:0] evt_level;
    logic [7:0] paddr, dma_channel_end;
    logic [11:0] evt_code, last;
    logic [31:0] pwdata, prdata, q, v;
    int fails, checks, seed, lv[17], cd[17];
    bit rq[17];
    always #25 pclk = ~pclk;
    intc_prio_coder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .nmi_pin, .ext_level_lines_n, .debug_interface_source, .gpio_source, .dma_channel_end,
        .dma_address_error, .core_accept, .evt_valid, .evt_code, .evt_level, .irq);
    core_take_model core (.pclk, .presetn, .evt_valid, .stall, .core_accept);
    task stop_test();
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        check("pready", pready, 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task set_c(input logic [15:0] d);
        apb(1'b1, `OFF_PRIO_C, {16'h0, d});
        apb(1'b0, `OFF_PRIO_C, 32'h0);
        check("prio_c", q, {16'h0, d});
        lv[6] = d[3:0];
        lv[7] = d[15:12];
        for (int j = 8; j < 17; j++)
            lv[j] = d[11:8];
    endtask
    task quiet(input string n);
        logic s;
        s = 1'b0;
        repeat (15) begin
            @(posedge pclk);
            s = s | evt_valid;
        end
        check(n, s, 0);
    endtask
    function int best();
        int b;
        b = -1;
        for (int j = 0; j < 17; j++)
            if (rq[j] && lv[j] > 0 && (b < 0 || lv[j] > lv[b]))
                b = j;
        return b;
    endfunction
    task drop(input int i);
        case (i)
            0: ;
            1: ext_level_lines_n <= 4'hF;
            2, 3, 4, 5: ext_level_lines_n[i-2] <= 1'b1;
            6: debug_interface_source <= 1'b0;
            7: gpio_source <= 1'b0;
            16: dma_address_error <= 1'b0;
            default: dma_channel_end[i-8] <= 1'b0;
        endcase
    endtask
    // drop early: pins need several edges to clear the filter
    task take();
        int i, k;
        i = best();
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (evt_valid !== 1'b1 && k < 80);
        check("evt_valid", evt_valid, 1'b1);
        check("evt_code", evt_code, cd[i]);
        check("evt_level", evt_level, lv[i]);
        drop(i);
        do begin
            @(posedge pclk);
            k++;
        end while (!(evt_valid === 1'b1 && core_accept === 1'b1) && k < 120);
        check("core_took", core_accept, 1'b1);
        rq[i] = 1'b0;
        last = cd[i];
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        stop_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {nmi_pin, debug_interface_source, gpio_source, dma_address_error, dma_channel_end} = '0;
        ext_level_lines_n = 4'hF;
        stall = 4'h8;
        presetn = 1'b0;
        seed = 32'hACB4;
        cd[0] = 12'h1C0;
        lv[0] = 16;
        for (int j = 0; j < 4; j++) begin
            cd[2+j] = 12'h240 + j * 12'h60;
            lv[2+j] = 13 - 3 * j;
        end
        cd[6] = 12'h600;
        cd[7] = 12'h620;
        for (int j = 0; j < 8; j++)
            cd[8+j] = (j < 4) ? 12'h640 + j * 12'h20 : 12'h780 + (j - 4) * 12'h20;
        cd[16] = 12'h6C0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 36; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            check("reset_value", q, a == 16 ? 32'hDA74 : 32'h0);
        end
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped_err", err, 1);
        check("unmapped_data", q, 0);
        gpio_source <= 1'b1;
        quiet("masked_source");
        gpio_source <= 1'b0;
        stall <= 4'h0;
        for (int r = 0; r < 2; r++) begin
            v = $random(seed);
            set_c(r == 0 ? 16'h5505 : {v[3:0] | 4'h1, v[7:4] | 4'h1, 4'h0, v[11:8] | 4'h1});
            debug_interface_source <= 1'b1;
            gpio_source <= 1'b1;
            dma_channel_end <= 8'hFF;
            dma_address_error <= 1'b1;
            for (int j = 6; j < 17; j++)
                rq[j] = 1'b1;
            repeat (11) take();
        end
        apb(1'b0, `OFF_EVENT_CODE, 32'h0);
        check("event_code_reg", q, {20'h0, last});
        stall <= 4'h8;
        for (int n = 0; n < 15; n++) begin
            lv[1] = 15 - n;
            cd[1] = 12'h200 + n * 12'h20;
            rq[1] = 1'b1;
            ext_level_lines_n <= n[3:0];
            take();
        end
        ext_level_lines_n <= 4'h0;
        repeat (2) @(posedge pclk);
        ext_level_lines_n <= 4'hF;
        quiet("short_glitch");
        apb(1'b1, `OFF_CTRL, 32'h180);
        ext_level_lines_n <= 4'h0;
        for (int j = 2; j < 6; j++)
            rq[j] = 1'b1;
        repeat (4) take();
        nmi_pin <= 1'b1;
        rq[0] = 1'b1;
        take();
        quiet("nmi_once");
        apb(1'b0, `OFF_CTRL, 32'h0);
        check("ctrl_nmi_level", q, 32'h8180);
        apb(1'b1, `OFF_CTRL, 32'h80);
        nmi_pin <= 1'b0;
        rq[0] = 1'b1;
        take();
        apb(1'b0, `OFF_CTRL, 32'h0);
        check("ctrl_falling", q, 32'h80);
        apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
        check("accept_flag", q[0], 1);
        check("irq_masked", irq, 0);
        apb(1'b1, `OFF_IRQ_MASK, 32'h7);
        repeat (2) @(posedge pclk);
        check("irq_on", irq, 1);
        apb(1'b1, `OFF_IRQ_STATUS, 32'h7);
        repeat (2) @(posedge pclk);
        check("irq_off", irq, 0);
        stop_test();
    end
endmodule
`default_nettype wire
